// ==== bench/hbh_host_model.sv ====
module hbh_host_model (
    input wire logic syncReadyN,
    output logic localBusClk = 1'h0,
    output logic cycleN = 1'h1,
    output logic writeNotRead = 1'h0,
    output logic readyReturnN = 1'h1
);
    timeunit 1ns / 1ps;
    // One 160 ns bus clock period; outside frames the clock stands still
    task automatic tick();
        #80 localBusClk = 1'h1;
        #80 localBusClk = 1'h0;
    endtask
    // Sync cycle; ready-return low over the first stall periods holds a burst back
    task automatic cycle(input logic wr, input int stall, output int p, output logic held);
        {writeNotRead, cycleN, readyReturnN} = {wr, 1'h0, stall == 0};
        for (p = 0; p < 12 && syncReadyN !== 1'h0; p++) begin
            tick();
            readyReturnN = readyReturnN || p + 1 == stall;
        end
        cycleN = 1'h1;
        tick();
        held = syncReadyN === 1'h0;
        readyReturnN = 1'h0;
        tick();
        {writeNotRead, readyReturnN} = {!wr, 1'h1};
    endtask
endmodule

// ==== bench/hbh_monitor.sv ====
module hbh_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    input wire logic noWaitBit,
    input wire logic [2:0] readFifoBytes,
    input wire logic writeFifoFull,
    input wire logic statusEvent,
    input wire logic asyncReadyOe,
    input wire logic hostIrqOut
);
    timeunit 1ns / 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Lone strobes, so read and write cases stay apart
    wire logic rd = !readStrobeN && writeStrobeN, wr = !writeStrobeN && readStrobeN;
    // Read with no wait cause
    sequence s_rd_ok;
        rd && noWaitBit && readFifoBytes >= 3'h4;
    endsequence
    // Four clocks cover two sync flops and the output flop
    a_cfg_rd: assert property ((rd && !noWaitBit) [*4] |-> asyncReadyOe) else $error("cfg rd");
    a_cfg_wr: assert property ((wr && !noWaitBit) [*4] |-> asyncReadyOe) else $error("cfg wr");
    a_rd_short: assert property ((rd && readFifoBytes < 3'h4) [*4] |-> asyncReadyOe)
        else $error("short read fifo");
    a_wr_full: assert property ((wr && writeFifoFull) [*4] |-> asyncReadyOe)
        else $error("full write fifo");
    a_rd_ok: assert property (s_rd_ok [*4] |-> !asyncReadyOe) else $error("read held");
    a_wr_ok: assert property ((wr && noWaitBit && !writeFifoFull) [*4] |-> !asyncReadyOe)
        else $error("write held");
    a_idle_free: assert property ((readStrobeN && writeStrobeN) [*4] |-> !asyncReadyOe)
        else $error("idle held");
    a_irq_follow: assert property ($past(rstn) |-> hostIrqOut == $past(statusEvent))
        else $error("irq");
endmodule
bind hbh_host_port hbh_monitor i_hbh_monitor (.*);

// ==== bench/testbench.sv ====
module testbench;
    timeunit 1ns / 1ps;
    logic clk = 1'h0, rstn = 1'h0, addrQualifier = 1'h0, noWaitBit = 1'h1, held;
    logic readStrobeN = 1'h1, writeStrobeN = 1'h1, datapathSelectN = 1'h1;
    logic vlModeSelectN = 1'h0, writeFifoFull = 1'h0, statusEvent = 1'h0;
    logic asyncReadyOut, asyncReadyOe, syncReadyN, localDeviceSelectN, datapathGrant;
    logic hostIrqOut, localBusClk, cycleN, writeNotRead, readyReturnN;
    logic [11:0] addrHigh = 12'h5a3;
    logic [7:0] baseAddrHigh = 8'h5a;
    logic [3:0] byteLaneEnableN = 4'h5, effByteEnable;
    logic [2:0] readFifoBytes = 3'h7;
    logic [1:0] irqSelectBits = 2'h3;
    logic [6:0] tbl [8] = '{7'h78, 7'h7a, 7'h39, 7'h3b, 7'h59, 7'h60, 7'h7f, 7'h7c};
    int fails = 0, cmp_count = 0, p;
    hbh_host_port i_hbh_host_port (.*);
    hbh_host_model i_hbh_host_model (.*);
    // Clock, and a watchdog far past the few microseconds needed
    always #5 clk = !clk;
    initial #50000 close_out(1);
    task automatic st(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string s, input logic [11:0] e, g);
        cmp_count++;
        fails += (g !== e);
        if (g !== e) $display("wrong value %s expected %h seen %h", s, e, g);
    endtask
    task automatic close_out(input int late);
        fails += late;
        $display("checks %0d fails %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Table rows: zero-wait, read level, write full, write, expected wait
    initial begin
        st(20);
        rstn = 1'h1;
        foreach (tbl[i]) begin
            {noWaitBit, readFifoBytes, writeFifoFull} = tbl[i][6:2];
            st(2);
            {readStrobeN, writeStrobeN} = {tbl[i][1], !tbl[i][1]};
            st(5);
            chk("wait", tbl[i][0], asyncReadyOe);
            chk("pull low", 0, asyncReadyOut);
            {readStrobeN, writeStrobeN} = 2'h3;
            st(5);
        end
        chk("hit", 0, localDeviceSelectN);
        {addrQualifier, datapathSelectN, statusEvent} = 3'h5;
        irqSelectBits = 2'h0;
        #1 chk("qualifier", 1, localDeviceSelectN);
        st(2);
        chk("grant", 1, datapathGrant);
        chk("lanes", 4'hf, effByteEnable);
        chk("irq", 1, hostIrqOut);
        {addrQualifier, datapathSelectN, statusEvent} = 3'h2;
        addrHigh = 12'h5b3;
        #1 chk("miss", 1, localDeviceSelectN);
        i_hbh_host_model.cycle(0, 0, p, held);
        chk("vl", 2, p[11:0]);
        chk("stand", 1, held);
        chk("back", 1, syncReadyN);
        chk("lanes free", 4'ha, effByteEnable);
        chk("irq off", 0, hostIrqOut);
        chk("grant off", 0, datapathGrant);
        i_hbh_host_model.cycle(1, 0, p, held);
        chk("write", 0, held);
        vlModeSelectN = 1'h1;
        i_hbh_host_model.cycle(1, 3, p, held);
        chk("stall", 1, p > 3);
        close_out(0);
    end
endmodule

// ==== pkg/hbh_pkg.sv ====
// Summary of operation
// - Async ready is pulled low during an async access when zero-wait bit is clear.
// - Async ready is pulled low on an async read while read FIFO has under 4 bytes.
// - Async ready is pulled low on an async write while the write FIFO is full.
// - Async ready release is timed from the crystal clock; host treats it as asynchronous.
// - In VL mode sync ready stays high and falls to signal completion.
// - Sync ready is generated from edges of the host local bus clock.
// - Host drives ready-return low to complete synchronous read cycles.
// - In burst mode ready-return is sampled on falling bus clock; cycles wait until high.
// - Single interrupt output goes high when any status event is pending.
// - Former interrupt-line select bits are reserved and change nothing.
// - Local select goes low when qualifier low and A8-A15 match base address high byte.
// - Local select is combinational from unlatched address and qualifier.
// - Data path select low grants data path access regardless of address and bank.
// - Data path burst transfers move 32 bits each, both directions.
// - Mode select low picks VL cycles, high picks burst cycles; async unaffected.
// - Host drives direction high for synchronous writes, low for reads.
// - Byte-lane enables are ignored while data path select is low.
package hbh_pkg;
    localparam int ADDR_LO = 4;
    localparam int ADDR_HI = 15;
    localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam logic [3:0] BE_FULL = 4'hf;
    localparam logic [2:0] FIFO_MIN_BYTES = 3'h4;
    localparam logic [2:0] FIFO_LVL_RST = 3'h0;
    localparam logic SYNC_RDY_IDLE = 1'h1;

    typedef enum {
        SC_IDLE,
        SC_WAIT,
        SC_DONE
    } hbh_sync_state_type;
endpackage

// ==== pkg/hbh_sync_if.sv ====
// Synchronised link pins travelling from the front end to the control logic
interface hbh_sync_if;
    logic lclkRise;
    logic lclkFall;
    logic cycleN;
    logic writeNotRead;
    logic readyReturnN;
    logic readStrobeN;
    logic writeStrobeN;
    modport producer(output lclkRise, lclkFall, cycleN, writeNotRead, readyReturnN,
        readStrobeN, writeStrobeN);
    modport consumer(input lclkRise, lclkFall, cycleN, writeNotRead, readyReturnN,
        readStrobeN, writeStrobeN);
endinterface

// ==== rtl/hbh_host_port.sv ====
// Host handshake port: async ready, sync ready, local decode, data path grant, interrupt
module hbh_host_port (
    input wire logic clk,
    input wire logic rstn,
    input wire logic localBusClk,
    input wire logic [hbh_pkg::ADDR_W-1:0] addrHigh,
    input wire logic addrQualifier,
    input wire logic [7:0] baseAddrHigh,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    input wire logic datapathSelectN,
    input wire logic [hbh_pkg::BE_W-1:0] byteLaneEnableN,
    input wire logic vlModeSelectN,
    input wire logic cycleN,
    input wire logic writeNotRead,
    input wire logic readyReturnN,
    input wire logic noWaitBit,
    input wire logic [1:0] irqSelectBits,
    input wire logic [2:0] readFifoBytes,
    input wire logic writeFifoFull,
    input wire logic statusEvent,
    output logic asyncReadyOut,
    output logic asyncReadyOe,
    output logic syncReadyN,
    output logic localDeviceSelectN,
    output logic datapathGrant,
    output logic [hbh_pkg::BE_W-1:0] effByteEnable,
    output logic hostIrqOut
);
    hbh_sync_if sy();

    hbh_pin_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .localBusClk(localBusClk),
        .cycleN(cycleN),
        .writeNotRead(writeNotRead),
        .readyReturnN(readyReturnN),
        .readStrobeN(readStrobeN),
        .writeStrobeN(writeStrobeN),
        .sy(sy.producer)
    );

    typedef struct packed {
        hbh_pkg::hbh_sync_state_type sst;
        logic srdyN;
        logic waitAsync;
        logic irq;
        logic grant;
        logic [hbh_pkg::BE_W-1:0] be;
        logic rtnHighSeen;
    } hbh_hp_type;

    hbh_hp_type st_reg;
    hbh_hp_type st_next;
    logic asyncRead;
    logic asyncWrite;
    logic burstMode;

    // Local select is a pure decode of raw pins so it beats any strobe latching
    assign localDeviceSelectN = ~(~addrQualifier
        && addrHigh[hbh_pkg::ADDR_W-1 -: 8] == baseAddrHigh);

    assign asyncRead = ~sy.readStrobeN;
    assign asyncWrite = ~sy.writeStrobeN;
    assign burstMode = vlModeSelectN;

    // Open drain: drive low only while waiting, otherwise release to the pull-up
    assign asyncReadyOut = 1'h0;
    assign asyncReadyOe = st_reg.waitAsync;
    assign syncReadyN = st_reg.srdyN;
    assign datapathGrant = st_reg.grant;
    assign effByteEnable = st_reg.be;
    assign hostIrqOut = st_reg.irq;

    always_comb begin
        st_next = st_reg;
        // Wait terms sampled on our own clock, which stands in for the crystal clock
        st_next.waitAsync = ((asyncRead || asyncWrite) && !noWaitBit)
            || (asyncRead && readFifoBytes < hbh_pkg::FIFO_MIN_BYTES)
            || (asyncWrite && writeFifoFull);
        // Interrupt select bits are reserved: deliberately not read here
        st_next.irq = statusEvent;
        st_next.grant = ~datapathSelectN;
        // Burst path is always a full word, so lane enables lose their meaning
        st_next.be = datapathSelectN ? ~byteLaneEnableN : hbh_pkg::BE_FULL;
        if (sy.lclkFall) begin
            st_next.rtnHighSeen = sy.readyReturnN;
        end
        // Sync ready only moves on bus clock rising edges
        if (sy.lclkRise) begin
            case (st_reg.sst)
                hbh_pkg::SC_IDLE: begin
                    st_next.srdyN = hbh_pkg::SYNC_RDY_IDLE;
                    if (!sy.cycleN) begin
                        st_next.sst = hbh_pkg::SC_WAIT;
                    end
                end
                hbh_pkg::SC_WAIT: begin
                    if (!burstMode) begin
                        st_next.srdyN = 1'h0;
                        st_next.sst = hbh_pkg::SC_DONE;
                    end else if (st_reg.rtnHighSeen) begin
                        st_next.srdyN = 1'h0;
                        st_next.sst = hbh_pkg::SC_DONE;
                    end
                end
                hbh_pkg::SC_DONE: begin
                    // Reads hold until the host returns ready; writes finish at once
                    if (sy.writeNotRead || !sy.readyReturnN) begin
                        st_next.srdyN = hbh_pkg::SYNC_RDY_IDLE;
                        st_next.sst = hbh_pkg::SC_IDLE;
                    end
                end
                default: begin
                    st_next.sst = hbh_pkg::SC_IDLE;
                    st_next.srdyN = hbh_pkg::SYNC_RDY_IDLE;
                end
            endcase
        end
        if (!rstn) begin
            st_next.sst = hbh_pkg::SC_IDLE;
            st_next.srdyN = hbh_pkg::SYNC_RDY_IDLE;
            st_next.waitAsync = 1'h0;
            st_next.irq = 1'h0;
            st_next.grant = 1'h0;
            st_next.be = hbh_pkg::BE_FULL;
            st_next.rtnHighSeen = 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end
endmodule

// ==== rtl/hbh_pin_sync.sv ====
// Two-flop synchronisers for the bus clock, cycle, direction, ready-return and strobe pins, plus clock edges
module hbh_pin_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic localBusClk,
    input wire logic cycleN,
    input wire logic writeNotRead,
    input wire logic readyReturnN,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    hbh_sync_if.producer sy
);
    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic clkOld;
    } hbh_ps_type;

    hbh_ps_type st_reg;
    hbh_ps_type st_next;

    // First stage feeds only the second stage; edges compare stage two only
    always_comb begin
        st_next = st_reg;
        st_next.s1 = {localBusClk, cycleN, writeNotRead, readyReturnN, readStrobeN,
            writeStrobeN};
        st_next.s2 = st_reg.s1;
        st_next.clkOld = st_reg.s2[5];
        if (!rstn) begin
            // Bus clock idles low between frames; matching it avoids a false edge
            st_next = '{s1: 6'h1f, s2: 6'h1f, clkOld: 1'h0};
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign sy.lclkRise = st_reg.s2[5] & ~st_reg.clkOld;
    assign sy.lclkFall = ~st_reg.s2[5] & st_reg.clkOld;
    assign sy.cycleN = st_reg.s2[4];
    assign sy.writeNotRead = st_reg.s2[3];
    assign sy.readyReturnN = st_reg.s2[2];
    assign sy.readStrobeN = st_reg.s2[1];
    assign sy.writeStrobeN = st_reg.s2[0];
endmodule
